// File: srpg_burst_mode_select_generator.sv
// Burst_mode_select generator with Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Path enable defaults off; pairs with select value 2.
// - Prescaler accepts only 1, 2, 4.
// - Echo select: 0 master, 1 repeater.
// - Repeater re-clocks request pin onto second output.
// - Burst select: 0 continuous, 1 counted pulses.
// - Burst length 0 to 15, reset 4.
// - Divider code k divides by 4 plus 2k.
// - Master pulse rate is clock over prescaler times divider ratio.
// - SYSREF leaves only on second output, differential.
// - Repeater supports counted or continuous bursts.
module srpg_burst_mode_select_generator (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	input wire logic frameRequestPin,
	output srpg_pkg::srpg_diff_t secondRfOutput,
	output logic [1:0] secondOutputSelect,
	output srpg_pkg::srpg_weights_t delayWeightWords
);

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	logic pulsePathEnable_reg;
	logic echoModeSelect_reg;
	logic burstModeSelect_reg;
	logic [2:0] interpPrescaler_reg;
	logic [1:0] secondOutputSelect_reg;
	logic [3:0] burstLength_reg;
	logic [10:0] frameClockDivider_reg;
	srpg_pkg::srpg_weights_t weights_reg;
	logic ack_reg;
	logic [31:0] readData_reg;
	logic [1:0] preCnt_reg;
	logic interpTick;
	logic prescalerBad;
	logic pathActive;
	logic pathMismatch;
	logic reqPrev_reg;
	logic reqLevel_reg;
	logic waveLevel_reg;
	logic [11:0] halfCnt_reg;
	logic [11:0] halfLen;
	logic [3:0] pulseCnt_reg;
	logic burstDone;
	logic srcLevel;
	logic srcFall;
	logic masterGate;
	logic restart;
	logic outLevel_reg;
	logic accept;
	logic [31:0] beMask;
	logic [31:0] ctrlWord;
	logic [31:0] delayWord;
	logic [31:0] statusWord;
	logic [7:0] weightSum;
	logic delayBad;

	// -----------------------------------------------------------------
	// Avalon-MM slave handshake
	// -----------------------------------------------------------------
	// Every access waits exactly one cycle, so read data can be
	// registered before waitrequest drops.
	assign avsWaitRequest = (avsRead | avsWrite) & ~ack_reg;
	assign accept = (avsRead | avsWrite) & ack_reg;
	assign beMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
		{8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};

	// The acknowledge drops after each accepted access.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avsRead | avsWrite) & ~ack_reg;
		end
	end

	// Packed views of the registers as software sees them.
	assign ctrlWord = {22'h00_0000, secondOutputSelect_reg, 1'b0,
		interpPrescaler_reg, 1'b0, burstModeSelect_reg,
		echoModeSelect_reg, pulsePathEnable_reg};
	assign delayWord = {2'h0, weights_reg.w4, 2'h0, weights_reg.w3,
		2'h0, weights_reg.w2, 2'h0, weights_reg.w1};
	assign statusWord = {21'h00_0000, delayBad, pathMismatch,
		prescalerBad, pulseCnt_reg, 2'h0, burstDone, outLevel_reg};

	// Read data is captured in the wait cycle; unmapped reads give zero.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			readData_reg <= 32'h0000_0000;
		end else if (avsRead && !ack_reg) begin
			unique case (avsAddress)
				srpg_pkg::OFF_CTRL: readData_reg <= ctrlWord;
				srpg_pkg::OFF_BURST: readData_reg <= {28'h000_0000,
					burstLength_reg};
				srpg_pkg::OFF_DIVIDER: readData_reg <= {21'h00_0000,
					frameClockDivider_reg};
				srpg_pkg::OFF_DELAY: readData_reg <= delayWord;
				srpg_pkg::OFF_STATUS: readData_reg <= statusWord;
				default: readData_reg <= 32'h0000_0000;
			endcase
		end
	end
	assign avsReadData = readData_reg;

	// -----------------------------------------------------------------
	// Configuration registers
	// -----------------------------------------------------------------
	// Control fields; path enable resets to disabled.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pulsePathEnable_reg <= srpg_pkg::RST_EN;
			echoModeSelect_reg <= srpg_pkg::RST_ECHO;
			burstModeSelect_reg <= srpg_pkg::RST_BURST;
			interpPrescaler_reg <= srpg_pkg::RST_PRE;
			secondOutputSelect_reg <= srpg_pkg::RST_MUX;
		end else if (accept && avsWrite &&
				avsAddress == srpg_pkg::OFF_CTRL) begin
			if (avsByteEnable[0]) begin
				pulsePathEnable_reg <= avsWriteData[srpg_pkg::CTRL_EN_BIT];
				echoModeSelect_reg <= avsWriteData[srpg_pkg::CTRL_ECHO_BIT];
				burstModeSelect_reg <=
					avsWriteData[srpg_pkg::CTRL_BURST_BIT];
				interpPrescaler_reg <=
					avsWriteData[srpg_pkg::CTRL_PRE_LSB +: 3];
			end
			if (avsByteEnable[1]) begin
				secondOutputSelect_reg <=
					avsWriteData[srpg_pkg::CTRL_MUX_LSB +: 2];
			end
		end
	end

	// Burst length holds any value 0 to 15, zero included.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			burstLength_reg <= srpg_pkg::RST_BURST_LEN;
		end else if (accept && avsWrite && avsByteEnable[0] &&
				avsAddress == srpg_pkg::OFF_BURST) begin
			burstLength_reg <= avsWriteData[3:0];
		end
	end

	// Divider code, merged by byte lane.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			frameClockDivider_reg <= srpg_pkg::RST_DIVIDER;
		end else if (accept && avsWrite &&
				avsAddress == srpg_pkg::OFF_DIVIDER) begin
			frameClockDivider_reg <= (frameClockDivider_reg &
				~beMask[10:0]) | (avsWriteData[10:0] & beMask[10:0]);
		end
	end

	// Delay weights; each byte lane carries one six-bit word.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			weights_reg.w1 <= srpg_pkg::RST_W1;
			weights_reg.w2 <= srpg_pkg::RST_W2;
			weights_reg.w3 <= srpg_pkg::RST_W3;
			weights_reg.w4 <= srpg_pkg::RST_W4;
		end else if (accept && avsWrite &&
				avsAddress == srpg_pkg::OFF_DELAY) begin
			if (avsByteEnable[0]) begin
				weights_reg.w1 <= avsWriteData[srpg_pkg::DELAY_W1_LSB +: 6];
			end
			if (avsByteEnable[1]) begin
				weights_reg.w2 <= avsWriteData[srpg_pkg::DELAY_W2_LSB +: 6];
			end
			if (avsByteEnable[2]) begin
				weights_reg.w3 <= avsWriteData[srpg_pkg::DELAY_W3_LSB +: 6];
			end
			if (avsByteEnable[3]) begin
				weights_reg.w4 <= avsWriteData[srpg_pkg::DELAY_W4_LSB +: 6];
			end
		end
	end

	// The device cannot fix a bad weight set; it only flags it.
	assign weightSum = {2'h0, weights_reg.w1} + {2'h0, weights_reg.w2} +
		{2'h0, weights_reg.w3} + {2'h0, weights_reg.w4};
	assign delayBad = (weightSum != srpg_pkg::WEIGHT_SUM);
	assign delayWeightWords = weights_reg;

	// -----------------------------------------------------------------
	// Interpolator prescaler
	// -----------------------------------------------------------------
	// Invalid codes stop the interpolator ticks altogether.
	assign prescalerBad = (interpPrescaler_reg != srpg_pkg::PRE_DIV1) &&
		(interpPrescaler_reg != srpg_pkg::PRE_DIV2) &&
		(interpPrescaler_reg != srpg_pkg::PRE_DIV4);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			preCnt_reg <= 2'h0;
		end else if (interpTick || prescalerBad) begin
			preCnt_reg <= 2'h0;
		end else begin
			preCnt_reg <= preCnt_reg + 2'h1;
		end
	end

	// One-cycle tick at the interpolator rate.
	always_comb begin
		unique case (interpPrescaler_reg)
			srpg_pkg::PRE_DIV1: interpTick = 1'b1;
			srpg_pkg::PRE_DIV2: interpTick = (preCnt_reg == 2'h1);
			srpg_pkg::PRE_DIV4: interpTick = (preCnt_reg == 2'h3);
			default: interpTick = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------
	// Path gating and restart
	// -----------------------------------------------------------------
	assign pathActive = pulsePathEnable_reg &&
		(secondOutputSelect_reg == srpg_pkg::MUX_SYSREF);
	assign pathMismatch = pulsePathEnable_reg !=
		(secondOutputSelect_reg == srpg_pkg::MUX_SYSREF);
	assign masterGate = pathActive && !echoModeSelect_reg &&
		frameRequestPin;

	// A fresh burst starts on reconfiguration, an explicit restart,
	// or a new high request level in master mode.
	assign restart = (accept && avsWrite &&
		(avsAddress == srpg_pkg::OFF_CTRL ||
		avsAddress == srpg_pkg::OFF_BURST ||
		avsAddress == srpg_pkg::OFF_DIVIDER ||
		(avsAddress == srpg_pkg::OFF_RESTART && avsWriteData[0]))) ||
		(!echoModeSelect_reg && frameRequestPin && !reqPrev_reg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reqPrev_reg <= 1'b0;
		end else begin
			reqPrev_reg <= frameRequestPin;
		end
	end

	// -----------------------------------------------------------------
	// Master wave generator
	// -----------------------------------------------------------------
	// Ratio 4 + 2k gives an even period, so each half is 2 + k ticks.
	assign halfLen = srpg_pkg::HALF_BASE +
		{1'b0, frameClockDivider_reg};

	// The wave restarts low whenever the gate closes, which keeps the
	// first pulse after a request aligned to the request.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			halfCnt_reg <= 12'h000;
			waveLevel_reg <= 1'b0;
		end else if (!masterGate || restart) begin
			halfCnt_reg <= 12'h000;
			waveLevel_reg <= 1'b0;
		end else if (interpTick) begin
			if (halfCnt_reg == halfLen - 12'h001) begin
				halfCnt_reg <= 12'h000;
				waveLevel_reg <= ~waveLevel_reg;
			end else begin
				halfCnt_reg <= halfCnt_reg + 12'h001;
			end
		end
	end

	// -----------------------------------------------------------------
	// Repeater re-clocking
	// -----------------------------------------------------------------
	// Both request edges are moved onto interpolator ticks.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reqLevel_reg <= 1'b0;
		end else if (!pathActive || !echoModeSelect_reg) begin
			reqLevel_reg <= 1'b0;
		end else if (interpTick) begin
			reqLevel_reg <= frameRequestPin;
		end
	end

	// -----------------------------------------------------------------
	// Burst counter
	// -----------------------------------------------------------------
	assign srcLevel = echoModeSelect_reg ? reqLevel_reg : waveLevel_reg;
	assign srcFall = interpTick && srcLevel && (echoModeSelect_reg ?
		(pathActive && !frameRequestPin) :
		(halfCnt_reg == halfLen - 12'h001));
	assign burstDone = burstModeSelect_reg &&
		(pulseCnt_reg >= burstLength_reg);

	// A pulse counts once its falling edge is seen.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pulseCnt_reg <= 4'h0;
		end else if (restart) begin
			pulseCnt_reg <= 4'h0;
		end else if (burstModeSelect_reg && srcFall && !burstDone) begin
			pulseCnt_reg <= pulseCnt_reg + 4'h1;
		end
	end

	// -----------------------------------------------------------------
	// Second RF output
	// -----------------------------------------------------------------
	// Once a burst is spent the output stays low until restart.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			outLevel_reg <= 1'b0;
		end else begin
			outLevel_reg <= pathActive && srcLevel && !burstDone &&
				(echoModeSelect_reg || frameRequestPin);
		end
	end

	// Differential pair driven from the one registered level.
	assign secondRfOutput.p = outLevel_reg;
	assign secondRfOutput.n = ~outLevel_reg;
	assign secondOutputSelect = secondOutputSelect_reg;

endmodule : srpg_burst_mode_select_generator

`default_nettype wire

// File: srpg_pkg.sv
// Package with register map, field layout, reset values and types.
`default_nettype none
package srpg_pkg;

	// -----------------------------------------------------------------
	// Register byte offsets
	// -----------------------------------------------------------------
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_BURST = 5'h04;
	localparam logic [4:0] OFF_DIVIDER = 5'h08;
	localparam logic [4:0] OFF_DELAY = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_RESTART = 5'h14;

	// -----------------------------------------------------------------
	// Control and delay register field positions
	// -----------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_ECHO_BIT = 1;
	localparam int CTRL_BURST_BIT = 2;
	localparam int CTRL_PRE_LSB = 4;
	localparam int CTRL_MUX_LSB = 8;
	localparam int DELAY_W1_LSB = 0;
	localparam int DELAY_W2_LSB = 8;
	localparam int DELAY_W3_LSB = 16;
	localparam int DELAY_W4_LSB = 24;

	// -----------------------------------------------------------------
	// Encodings and reset values
	// -----------------------------------------------------------------
	localparam logic [2:0] PRE_DIV1 = 3'h1;
	localparam logic [2:0] PRE_DIV2 = 3'h2;
	localparam logic [2:0] PRE_DIV4 = 3'h4;
	localparam logic [1:0] MUX_SYSREF = 2'h2;
	localparam logic RST_EN = 1'h0;
	localparam logic RST_ECHO = 1'h0;
	localparam logic RST_BURST = 1'h0;
	localparam logic [2:0] RST_PRE = 3'h1;
	localparam logic [1:0] RST_MUX = 2'h0;
	localparam logic [3:0] RST_BURST_LEN = 4'h4;
	localparam logic [10:0] RST_DIVIDER = 11'h000;
	localparam logic [5:0] RST_W1 = 6'h24;
	localparam logic [5:0] RST_W2 = 6'h1B;
	localparam logic [5:0] RST_W3 = 6'h00;
	localparam logic [5:0] RST_W4 = 6'h00;
	localparam logic [7:0] WEIGHT_SUM = 8'h3F;
	// Half period in interpolator ticks is this base plus the code.
	localparam logic [11:0] HALF_BASE = 12'h002;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic p;
		logic n;
	} srpg_diff_t;

	typedef struct packed {
		logic [5:0] w4;
		logic [5:0] w3;
		logic [5:0] w2;
		logic [5:0] w1;
	} srpg_weights_t;

endpackage : srpg_pkg

`default_nettype wire

// File: srpg_props.sv
// Checker for bus handshake and SYSREF output relations.
`timescale 1ns/1ps
`default_nettype none
module srpg_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire logic frameRequestPin,
	input wire srpg_pkg::srpg_diff_t secondRfOutput,
	input wire logic [1:0] secondOutputSelect,
	input wire srpg_pkg::srpg_weights_t delayWeightWords
);
	logic req;
	logic done;
	logic outP;
	logic selOff;
	logic ctrlWr;
	logic dlyAny;
	logic dlyWr;
	logic [1:0] selWd;
	srpg_pkg::srpg_weights_t dlyWd;
	// An access completes at the edge where waitrequest is seen low.
	assign req = avsRead | avsWrite;
	assign done = req & ~avsWaitRequest;
	assign outP = secondRfOutput.p;
	assign selOff = secondOutputSelect != srpg_pkg::MUX_SYSREF;
	assign ctrlWr = avsWrite & done & (avsAddress == srpg_pkg::OFF_CTRL)
		& avsByteEnable[1];
	assign dlyAny = avsWrite & done & (avsAddress == srpg_pkg::OFF_DELAY);
	assign dlyWr = dlyAny & (avsByteEnable == 4'hF);
	assign selWd = avsWriteData[9:8];
	assign dlyWd = {avsWriteData[29:24], avsWriteData[21:16],
		avsWriteData[13:8], avsWriteData[5:0]};
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Every access waits exactly one cycle, never more.
	a_wait_first: assert property (req && !$past(req) |-> avsWaitRequest)
		else $error("No wait cycle on a new request.");
	a_wait_once: assert property (req && avsWaitRequest |=> !avsWaitRequest)
		else $error("Wait lasted more than one cycle.");
	a_rd_hold: assert property (!avsRead |=> $stable(avsReadData))
		else $error("Read data moved without a read.");
	// The receiver needs true complementary legs.
	a_diff_legs: assert property (secondRfOutput.n == !outP)
		else $error("Output legs not complementary.");
	// One cycle of slack covers the registered output stage.
	a_sel_gate: assert property (selOff && $past(selOff) |-> !outP)
		else $error("Output high while not routed.");
	a_pin_low: assert property ((!frameRequestPin) [*8] |-> !outP)
		else $error("Output high with request pin low.");
	a_sel_write: assert property (ctrlWr
		|=> secondOutputSelect == $past(selWd))
		else $error("Select field not updated.");
	a_dly_write: assert property (dlyWr
		|=> delayWeightWords == $past(dlyWd))
		else $error("Delay weights not updated.");
	a_dly_hold: assert property (!dlyAny |=> $stable(delayWeightWords))
		else $error("Delay weights moved without a write.");
	c_pulse: cover property ($rose(outP));
	c_read: cover property (avsRead && done);
	c_write: cover property (avsWrite && done);
endmodule : srpg_props
bind srpg_burst_mode_select_generator srpg_props srpg_props_i (.mclk, .rst,
	.avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
	.avsReadData, .avsWaitRequest, .frameRequestPin, .secondRfOutput,
	.secondOutputSelect, .delayWeightWords);
`default_nettype wire

// File: srpg_rx_model.sv
// Converter-side model that receives and counts SYSREF pulses.
`timescale 1ns/1ps
`default_nettype none
module srpg_rx_model (
	input wire logic mclk,
	input wire srpg_pkg::srpg_diff_t sysrefIn,
	output int pulseCount,
	output logic pairBad
);
	logic lastP_reg = 1'b0;
	initial pulseCount = 0;
	initial pairBad = 1'b0;
	// Only the second output reaches the converter; rising edges count.
	always @(posedge mclk) begin
		lastP_reg <= sysrefIn.p;
		if (sysrefIn.p && !lastP_reg)
			pulseCount <= pulseCount + 1;
		// Equal legs cannot be read as a differential level. Before the
		// first reset edge both legs are unknown, which is not a fault.
		if ((sysrefIn.p ^ sysrefIn.n) === 1'b0)
			pairBad <= 1'b1;
	end
endmodule : srpg_rx_model
`default_nettype wire

// File: tb_burst_mode_select_generator.sv
// Self-checking testbench for the Burst_mode_select generator.
`timescale 1ns/1ps
`default_nettype none
module tb_burst_mode_select_generator;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avsAddress = 5'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0000_0000;
	logic [3:0] avsByteEnable = 4'hF;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	logic frameRequestPin = 1'b0;
	srpg_pkg::srpg_diff_t secondRfOutput;
	logic [1:0] secondOutputSelect;
	srpg_pkg::srpg_weights_t delayWeightWords;
	int pulseCount;
	logic pairBad;
	int n_mismatch = 0;
	int compares = 0;
	int base = 0;
	logic [31:0] rdv;
	time t0;
	time t1;
	time t2;
	// Design and the converter model on its second output.
	srpg_burst_mode_select_generator srpg_burst_mode_select_generator_i (.mclk, .rst,
		.avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
		.avsReadData, .avsWaitRequest, .frameRequestPin, .secondRfOutput,
		.secondOutputSelect, .delayWeightWords);
	srpg_rx_model srpg_rx_model_i (.mclk, .sysrefIn(secondRfOutput),
		.pulseCount, .pairBad);
	// Free-running 20 MHz clock.
	always #25 mclk = ~mclk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Bus master: hold the request until waitrequest is sampled low.
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= 1'b1;
		do @(posedge mclk); while (avsWaitRequest !== 1'b0);
		avsWrite <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		avsAddress <= a;
		avsRead <= 1'b1;
		do @(posedge mclk); while (avsWaitRequest !== 1'b0);
		rdv = avsReadData;
		avsRead <= 1'b0;
		@(posedge mclk);
		check(rdv, exp);
	endtask : rd
	// Quiet the path first so the pulse count starts from a low output.
	// The bench plays a controller whose synthesizer already sits in
	// phase sync mode with its folded divide worked out.
	task automatic cfg(input logic [31:0] c, input logic [3:0] len,
		input logic [10:0] k);
		wr(srpg_pkg::OFF_CTRL, 32'h0000_0010);
		wr(srpg_pkg::OFF_BURST, 32'(len));
		wr(srpg_pkg::OFF_DIVIDER, 32'(k));
		base = pulseCount;
		wr(srpg_pkg::OFF_CTRL, c);
	endtask : cfg
	task automatic cnt(input int cyc, input int exp);
		repeat (cyc) @(posedge mclk);
		check(32'(pulseCount - base), 32'(exp));
	endtask : cnt
	// The first pulse after a restart is skipped, it may be cut short.
	task automatic meas(input int hi, input int per);
		@(posedge secondRfOutput.p);
		@(posedge secondRfOutput.p);
		t0 = $time;
		@(negedge secondRfOutput.p);
		t1 = $time;
		@(posedge secondRfOutput.p);
		t2 = $time;
		check(32'((t1 - t0) / 50), 32'(hi));
		check(32'((t2 - t0) / 50), 32'(per));
	endtask : meas
	// Each requested pulse is a toggle of the request pin.
	task automatic pins(input int n);
		repeat (n) begin
			frameRequestPin <= 1'b1;
			repeat (4) @(posedge mclk);
			frameRequestPin <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask : pins
	task automatic t_defaults;
		check(32'(secondRfOutput), 32'h0000_0001);
		check(32'(secondOutputSelect), 32'h0000_0000);
		check(32'(delayWeightWords), 32'h0000_06E4);
		rd(srpg_pkg::OFF_CTRL, 32'h0000_0010);
		rd(srpg_pkg::OFF_BURST, 32'h0000_0004);
		rd(srpg_pkg::OFF_DIVIDER, 32'h0000_0000);
		rd(srpg_pkg::OFF_DELAY, 32'h0000_1B24);
		$display("t_defaults done");
	endtask : t_defaults
	task automatic t_bus;
		wr(5'h18, 32'hFFFF_FFFF);
		rd(5'h18, 32'h0000_0000);
		wr(srpg_pkg::OFF_RESTART, 32'h0000_0001);
		rd(srpg_pkg::OFF_RESTART, 32'h0000_0000);
		avsByteEnable <= 4'h1;
		wr(srpg_pkg::OFF_DIVIDER, 32'h0000_07FF);
		avsByteEnable <= 4'hF;
		rd(srpg_pkg::OFF_DIVIDER, 32'h0000_00FF);
		wr(srpg_pkg::OFF_DIVIDER, 32'h0000_07FF);
		rd(srpg_pkg::OFF_DIVIDER, 32'h0000_07FF);
		wr(srpg_pkg::OFF_BURST, 32'h0000_000F);
		rd(srpg_pkg::OFF_BURST, 32'h0000_000F);
		wr(srpg_pkg::OFF_DELAY, 32'h0000_3F00);
		rd(srpg_pkg::OFF_DELAY, 32'h0000_3F00);
		$display("t_bus done");
	endtask : t_bus
	// High time is 2+k ticks, period 4+2k ticks, a tick is pre cycles.
	task automatic t_master;
		frameRequestPin <= 1'b1;
		cfg(32'h0000_0211, 4'h4, 11'h000);
		check(32'(secondOutputSelect), 32'h0000_0002);
		meas(2, 4);
		cfg(32'h0000_0221, 4'h4, 11'h001);
		meas(6, 12);
		cfg(32'h0000_0241, 4'h4, 11'h005);
		meas(28, 56);
		cfg(32'h0000_0211, 4'h4, 11'h7FF);
		meas(2049, 4098);
		$display("t_master done");
	endtask : t_master
	task automatic t_gate;
		cfg(32'h0000_0231, 4'h4, 11'h000);
		cnt(60, 0);
		rd(srpg_pkg::OFF_STATUS, 32'h0000_0100);
		cfg(32'h0000_0011, 4'h4, 11'h000);
		cnt(60, 0);
		rd(srpg_pkg::OFF_STATUS, 32'h0000_0200);
		cfg(32'h0000_0210, 4'h4, 11'h000);
		cnt(60, 0);
		frameRequestPin <= 1'b0;
		cfg(32'h0000_0211, 4'h4, 11'h000);
		cnt(60, 0);
		$display("t_gate done");
	endtask : t_gate
	task automatic t_burst;
		frameRequestPin <= 1'b1;
		cfg(32'h0000_0215, 4'h3, 11'h000);
		cnt(100, 3);
		check(32'(secondRfOutput), 32'h0000_0001);
		rd(srpg_pkg::OFF_STATUS, 32'h0000_0032);
		base = pulseCount;
		wr(srpg_pkg::OFF_RESTART, 32'h0000_0001);
		cnt(100, 3);
		// A fresh rising request level in master mode restarts the burst.
		base = pulseCount;
		frameRequestPin <= 1'b0;
		@(posedge mclk);
		frameRequestPin <= 1'b1;
		cnt(100, 3);
		cfg(32'h0000_0215, 4'h0, 11'h000);
		cnt(60, 0);
		cfg(32'h0000_0215, 4'hF, 11'h000);
		cnt(150, 15);
		$display("t_burst done");
	endtask : t_burst
	task automatic t_repeat;
		frameRequestPin <= 1'b0;
		cfg(32'h0000_0213, 4'h4, 11'h000);
		pins(5);
		cnt(10, 5);
		frameRequestPin <= 1'b1;
		repeat (4) @(posedge mclk);
		check(32'(secondRfOutput), 32'h0000_0002);
		frameRequestPin <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			cfg(32'h0000_0217, 4'(1 << i), 11'h000);
			pins((1 << i) + 2);
			cnt(10, 1 << i);
		end
		$display("t_repeat done");
	endtask : t_repeat
	task automatic finish_test;
		$display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	// Main sequence: reset for ten cycles, then every test in turn.
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_defaults();
		t_bus();
		t_master();
		t_gate();
		t_burst();
		t_repeat();
		check(32'(pairBad), 32'h0000_0000);
		finish_test();
	end
	// Watchdog: the full run needs about 12000 cycles.
	initial begin
		repeat (40000) @(posedge mclk);
		n_mismatch++;
		$display("[FAIL] %0t ns: timeout", $time);
		finish_test();
	end
endmodule : tb_burst_mode_select_generator
`default_nettype wire
